//--- verilog/xps_consts.svh
`ifndef XPS_CONSTS_SVH
`define XPS_CONSTS_SVH

// register map, byte offsets on the register port
`define XPS_SEL_OFFSET 8'h24
`define XPS_CTRL_OFFSET 8'h28
`define XPS_STATUS_OFFSET 8'h2C

// select register fields
`define XPS_BIT_CAN_A 0
`define XPS_BIT_CAN_B 1
`define XPS_BIT_SMALL_XRAM 2
`define XPS_BIT_LARGE_XRAM 3
`define XPS_BIT_TIMEKEEPER 4
`define XPS_SEL_WIDTH 5
`define XPS_SEL_RESET 5'h05
`define XPS_SEL_ALL 5'h1F

// control register fields
`define XPS_BIT_GLOBAL_EN 0
`define XPS_BIT_OSC_OFF 1

// address windows (24-bit byte address)
`define XPS_CAN_A_LO 24'h00EF00
`define XPS_CAN_A_HI 24'h00EFFF
`define XPS_CAN_B_LO 24'h00EE00
`define XPS_CAN_B_HI 24'h00EEFF
`define XPS_SMALL_LO 24'h00E000
`define XPS_SMALL_HI 24'h00E7FF
`define XPS_LARGE_LO 24'h00C000
`define XPS_LARGE_HI 24'h00DFFF
`define XPS_TK_LO 24'h00EC00
`define XPS_TK_HI 24'h00ECFF

`endif

//--- verilog/xps_pkg.sv
package xps_pkg;
   typedef enum logic [2:0] {
      XPS_T_NONE,
      XPS_T_CAN_A,
      XPS_T_CAN_B,
      XPS_T_SMALL_XRAM,
      XPS_T_LARGE_XRAM,
      XPS_T_TIMEKEEPER,
      XPS_T_EXTERNAL
   } xps_target_t;
endpackage

//--- verilog/xps_sync.sv
`timescale 1ns/1ps
module xps_sync (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } xps_sync_state_t;

   xps_sync_state_t st;
   xps_sync_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3) begin
         next_st.q = st.s3;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.q;
endmodule

//--- verilog/xps_select_decode.sv
// Notes on behaviour
// (R1) can_a_enable low blocks CAN A, frees pins
// (R2) CAN A range external only if both off
// (R3) can_b_enable low blocks CAN B, frees pins
// (R4) CAN B range external only if both off
// (R5) small_xram_enable picks internal or external
// (R6) large_xram_enable picks internal or external
// (R7) timekeeper off: external only if CANs off
// (R8) both CANs off: CAN range goes external
// (R9) reset enables CAN A, small RAM only
// (R10) global enable locks the select register
// (R11) emulation mode forces all enables high
// (R12) timekeeper off: oscillator off in power-down
// (R13) timekeeper on: osc off follows control bit
// (R14) select bits 4..0, reset value 05h
// (R15) locked writes ignored silently, no error
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "xps_consts.svh"
module xps_select_decode (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic emulation_mode,
   input wire logic power_down_req,
   input wire logic acc_valid,
   input wire logic [23:0] acc_addr,
   output logic acc_route_valid,
   output xps_pkg::xps_target_t acc_target,
   output logic acc_blocked,
   output logic [23:0] acc_ext_addr,
   output logic can_a_pins_active,
   output logic can_b_pins_active,
   output logic [`XPS_SEL_WIDTH-1:0] periph_enable,
   output logic osc_stop
);
   import xps_pkg::*;

   typedef struct packed {
      logic [`XPS_SEL_WIDTH-1:0] sel;
      logic global_en;
      logic osc_off_ctrl;
      logic [15:0] rdata;
      logic route_valid;
      xps_target_t target;
      logic blocked;
      logic [23:0] ext_addr;
      logic pins_a;
      logic pins_b;
      logic [`XPS_SEL_WIDTH-1:0] en_out;
      logic osc_stop;
   } xps_state_t;

   xps_state_t st;
   xps_state_t next_st;
   logic [1:0] rst_sync;
   logic rst_n;
   logic emu_s;
   logic pd_s;

   // reset release through two flip-flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // pin inputs pass four flip-flops, the last loading only when the two before it agree
   xps_sync u_sync_emu (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(emulation_mode),
      .dout(emu_s)
   );

   xps_sync u_sync_pd (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(power_down_req),
      .dout(pd_s)
   );

   function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                   input logic [23:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   // effective enables and window hits
   logic [`XPS_SEL_WIDTH-1:0] eff;
   logic both_can_off;
   logic hit_can_a;
   logic hit_can_b;
   logic hit_small;
   logic hit_large;
   logic hit_tk;
   logic [4:0] hit_vec;
   logic can_a_hole;
   logic can_b_hole;
   logic tk_hole;

   // register port decode
   logic sel_wr;
   logic ctrl_wr;
   logic sel_wr_open;
   logic [`XPS_SEL_WIDTH-1:0] next_sel;
   logic next_global_en;
   logic next_osc_off;
   logic [15:0] sel_word;
   logic [15:0] ctrl_word;
   logic [15:0] status_word;
   logic [15:0] rd_word;

   // route and side outputs
   xps_target_t route_target;
   logic route_blocked;
   logic pins_a_now;
   logic pins_b_now;
   logic osc_stop_now;

   // emulation forces every peripheral on
   for (genvar i = 0; i < `XPS_SEL_WIDTH; i++) begin : g_force
      assign eff[i] = emu_s | st.sel[i]; // (R11)
   end

   always_comb begin
      both_can_off = !eff[`XPS_BIT_CAN_A] && !eff[`XPS_BIT_CAN_B];
      // a disabled CAN or timekeeper window is a hole unless both CANs are off
      can_a_hole = !eff[`XPS_BIT_CAN_A] && !both_can_off; // (R1) (R2)
      can_b_hole = !eff[`XPS_BIT_CAN_B] && !both_can_off; // (R3) (R4)
      tk_hole = !eff[`XPS_BIT_TIMEKEEPER] && !both_can_off; // (R7)
   end

   // window hits on the access address
   always_comb begin
      hit_can_a = in_rng(acc_addr, `XPS_CAN_A_LO, `XPS_CAN_A_HI);
      hit_can_b = in_rng(acc_addr, `XPS_CAN_B_LO, `XPS_CAN_B_HI);
      hit_small = in_rng(acc_addr, `XPS_SMALL_LO, `XPS_SMALL_HI);
      hit_large = in_rng(acc_addr, `XPS_LARGE_LO, `XPS_LARGE_HI);
      hit_tk = in_rng(acc_addr, `XPS_TK_LO, `XPS_TK_HI);
      hit_vec = {hit_tk, hit_large, hit_small, hit_can_b, hit_can_a};
   end

   // register port strobes
   always_comb begin
      sel_wr = reg_wr && (reg_addr == `XPS_SEL_OFFSET);
      ctrl_wr = reg_wr && (reg_addr == `XPS_CTRL_OFFSET);
      // locked write falls through with no effect (R15)
      sel_wr_open = sel_wr && !st.global_en; // (R10)
   end

   // register writes
   always_comb begin
      next_sel = st.sel;
      next_global_en = st.global_en;
      next_osc_off = st.osc_off_ctrl;
      if (sel_wr_open) begin
         next_sel = reg_wdata[`XPS_SEL_WIDTH-1:0]; // (R14)
      end
      if (ctrl_wr) begin
         // global enable is set-only until reset
         next_global_en = st.global_en | reg_wdata[`XPS_BIT_GLOBAL_EN];
         next_osc_off = reg_wdata[`XPS_BIT_OSC_OFF];
      end
   end

   // register words as software sees them
   always_comb begin
      sel_word = {11'h000, st.sel}; // (R14)
      ctrl_word = {14'h0000, st.osc_off_ctrl, st.global_en};
      status_word = {10'h000, emu_s, eff};
   end

   // read word, registered so it stands in the next cycle only
   always_comb begin
      rd_word = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            `XPS_SEL_OFFSET: rd_word = sel_word;
            `XPS_CTRL_OFFSET: rd_word = ctrl_word;
            `XPS_STATUS_OFFSET: rd_word = status_word;
            default: rd_word = 16'h0000;
         endcase
      end
   end

   // route decision for the access on the port
   always_comb begin
      route_target = XPS_T_NONE;
      route_blocked = 1'b0;
      if (acc_valid) begin
         unique case (hit_vec)
            5'h01: begin
               if (eff[`XPS_BIT_CAN_A]) begin
                  route_target = XPS_T_CAN_A; // (R1)
                  route_blocked = 1'b0;
               end else if (can_a_hole) begin
                  route_target = XPS_T_NONE; // (R1)
                  route_blocked = 1'b1;
               end else begin
                  route_target = XPS_T_EXTERNAL; // (R2) (R8)
                  route_blocked = 1'b0;
               end
            end
            5'h02: begin
               if (eff[`XPS_BIT_CAN_B]) begin
                  route_target = XPS_T_CAN_B; // (R3)
                  route_blocked = 1'b0;
               end else if (can_b_hole) begin
                  route_target = XPS_T_NONE; // (R3)
                  route_blocked = 1'b1;
               end else begin
                  route_target = XPS_T_EXTERNAL; // (R4) (R8)
                  route_blocked = 1'b0;
               end
            end
            5'h04: begin
               if (eff[`XPS_BIT_SMALL_XRAM]) begin
                  route_target = XPS_T_SMALL_XRAM; // (R5)
                  route_blocked = 1'b0;
               end else begin
                  route_target = XPS_T_EXTERNAL; // (R5)
                  route_blocked = 1'b0;
               end
            end
            5'h08: begin
               if (eff[`XPS_BIT_LARGE_XRAM]) begin
                  route_target = XPS_T_LARGE_XRAM; // (R6)
                  route_blocked = 1'b0;
               end else begin
                  route_target = XPS_T_EXTERNAL; // (R6)
                  route_blocked = 1'b0;
               end
            end
            5'h10: begin
               if (eff[`XPS_BIT_TIMEKEEPER]) begin
                  route_target = XPS_T_TIMEKEEPER; // (R7)
                  route_blocked = 1'b0;
               end else if (tk_hole) begin
                  route_target = XPS_T_NONE; // (R7)
                  route_blocked = 1'b1;
               end else begin
                  route_target = XPS_T_EXTERNAL; // (R7)
                  route_blocked = 1'b0;
               end
            end
            default: begin
               // outside every window
               route_target = XPS_T_EXTERNAL;
               route_blocked = 1'b0;
            end
         endcase
      end
   end

   // pin ownership follows the effective enables
   always_comb begin
      pins_a_now = eff[`XPS_BIT_CAN_A]; // (R1)
      pins_b_now = eff[`XPS_BIT_CAN_B]; // (R3)
   end

   // oscillator stop in power-down
   always_comb begin
      if (!eff[`XPS_BIT_TIMEKEEPER]) begin
         osc_stop_now = pd_s; // (R12)
      end else begin
         osc_stop_now = pd_s && st.osc_off_ctrl; // (R13)
      end
   end

   always_comb begin
      next_st = st;
      next_st.sel = next_sel;
      next_st.global_en = next_global_en;
      next_st.osc_off_ctrl = next_osc_off;
      next_st.rdata = rd_word;
      next_st.route_valid = acc_valid;
      next_st.target = route_target;
      next_st.blocked = route_blocked;
      next_st.ext_addr = acc_addr;
      next_st.pins_a = pins_a_now;
      next_st.pins_b = pins_b_now;
      next_st.en_out = eff;
      next_st.osc_stop = osc_stop_now;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         // register file
         st.sel <= `XPS_SEL_RESET; // (R9) (R14)
         st.global_en <= 1'b0;
         st.osc_off_ctrl <= 1'b0;
         st.rdata <= 16'h0000;

         // access route
         st.route_valid <= 1'b0;
         st.target <= XPS_T_NONE;
         st.blocked <= 1'b0;
         st.ext_addr <= 24'h000000;

         // side outputs
         st.pins_a <= 1'b1;
         st.pins_b <= 1'b0;
         st.en_out <= `XPS_SEL_RESET;
         st.osc_stop <= 1'b0;
      end else begin
         // register file
         st.sel <= next_st.sel;
         st.global_en <= next_st.global_en;
         st.osc_off_ctrl <= next_st.osc_off_ctrl;
         st.rdata <= next_st.rdata;

         // access route
         st.route_valid <= next_st.route_valid;
         st.target <= next_st.target;
         st.blocked <= next_st.blocked;
         st.ext_addr <= next_st.ext_addr;

         // side outputs
         st.pins_a <= next_st.pins_a;
         st.pins_b <= next_st.pins_b;
         st.en_out <= next_st.en_out;
         st.osc_stop <= next_st.osc_stop;
      end
   end

   // register port
   assign reg_rdata = st.rdata;

   // access route
   assign acc_route_valid = st.route_valid;
   assign acc_target = st.target;
   assign acc_blocked = st.blocked;
   assign acc_ext_addr = st.ext_addr;

   // side outputs
   assign can_a_pins_active = st.pins_a;
   assign can_b_pins_active = st.pins_b;
   assign periph_enable = st.en_out;
   assign osc_stop = st.osc_stop;
endmodule

//--- tb/xps_select_decode_asserts.sv
`timescale 1ns/1ps
`include "xps_consts.svh"
module xps_select_decode_asserts
   import xps_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic emulation_mode,
   input wire logic power_down_req,
   input wire logic acc_valid,
   input wire logic [23:0] acc_addr,
   input wire logic acc_route_valid,
   input var xps_target_t acc_target,
   input wire logic acc_blocked,
   input wire logic [23:0] acc_ext_addr,
   input wire logic can_a_pins_active,
   input wire logic can_b_pins_active,
   input wire logic [`XPS_SEL_WIDTH-1:0] periph_enable,
   input wire logic osc_stop
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence can_off_req;
      acc_valid && acc_addr >= `XPS_CAN_B_LO && acc_addr <= `XPS_CAN_A_HI
         && periph_enable[1:0] == 2'h0 && $stable(periph_enable);
   endsequence
   sequence large_on_req;
      acc_valid && acc_addr >= `XPS_LARGE_LO && acc_addr <= `XPS_LARGE_HI
         && periph_enable[3] && $stable(periph_enable);
   endsequence
   a_route_follows: assert property (acc_valid |=> acc_route_valid) else $error("no route");
   a_addr_copied: assert property (acc_valid |=> acc_ext_addr == $past(acc_addr)) else $error("addr");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("rdata");
   a_pins_a_owner: assert property (can_a_pins_active == periph_enable[0]) else $error("pa");
   a_pins_b_owner: assert property (can_b_pins_active == periph_enable[1]) else $error("pb");
   a_blocked_none: assert property (acc_route_valid && acc_blocked |-> acc_target == XPS_T_NONE)
      else $error("blocked");
   a_can_external: assert property (can_off_req |=> acc_target == XPS_T_EXTERNAL)
      else $error("can ext");
   a_large_internal: assert property (large_on_req |=> acc_target == XPS_T_LARGE_XRAM)
      else $error("large");
endmodule

//--- tb/xps_far_model.sv
`timescale 1ns/1ps
module xps_far_model (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [23:0] go_addr,
   output logic acc_valid,
   output logic [23:0] acc_addr
);
   initial acc_valid = 1'b0;
   initial acc_addr = 24'h000000;
   always @(posedge ref_clk) begin
      acc_valid <= go;
      acc_addr <= go ? go_addr : ~acc_addr;
   end
endmodule

//--- tb/xps_select_decode_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, a, e); end end
module xps_select_decode_tb;
   import xps_pkg::*;
   logic ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, emulation_mode = 0;
   logic power_down_req = 0, go = 0, acc_valid, acc_route_valid, acc_blocked;
   logic can_a_pins_active, can_b_pins_active, osc_stop;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [23:0] go_addr = 24'h000000, acc_addr, acc_ext_addr;
   logic [4:0] periph_enable;
   xps_target_t acc_target;
   logic [23:0] ext_list [5] = '{24'h00EF00, 24'h00EEFF, 24'h00EC00, 24'h00E000, 24'h123456};
   int err_count = 0, checked = 0;
   xps_select_decode dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .emulation_mode(emulation_mode), .power_down_req(power_down_req), .acc_valid(acc_valid),
      .acc_addr(acc_addr), .acc_route_valid(acc_route_valid), .acc_target(acc_target),
      .acc_blocked(acc_blocked), .acc_ext_addr(acc_ext_addr),
      .can_a_pins_active(can_a_pins_active), .can_b_pins_active(can_b_pins_active),
      .periph_enable(periph_enable), .osc_stop(osc_stop));
   xps_far_model far (.ref_clk(ref_clk), .go(go), .go_addr(go_addr), .acc_valid(acc_valid),
      .acc_addr(acc_addr));
   task automatic print_verdict;
      if (err_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      `CHK(reg_rdata, e)
   endtask
   task automatic dec(input logic [23:0] a, input xps_target_t t, input logic b);
      @(posedge ref_clk);
      go <= 1'b1;
      go_addr <= a;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(acc_route_valid, 1'b1)
      `CHK(acc_target, t)
      `CHK(acc_blocked, b)
      `CHK(acc_ext_addr, a)
   endtask
   task automatic st(input logic [4:0] pe, input logic [2:0] p);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(periph_enable, pe)
      `CHK({osc_stop, can_b_pins_active, can_a_pins_active}, p)
   endtask
   initial forever #12.5 ref_clk = ~ref_clk;
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      print_verdict;
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(8'h24, 16'h0005);
      st(5'h05, 3'b001);
      dec(24'h00EF10, XPS_T_CAN_A, 1'b0);
      dec(24'h00EE10, XPS_T_NONE, 1'b1);
      dec(24'h00EC10, XPS_T_NONE, 1'b1);
      dec(24'h00E7FF, XPS_T_SMALL_XRAM, 1'b0);
      dec(24'h00DFFF, XPS_T_EXTERNAL, 1'b0);
      wr(8'h24, 16'h001E);
      st(5'h1E, 3'b010);
      dec(24'h00EFFF, XPS_T_NONE, 1'b1);
      dec(24'h00EE00, XPS_T_CAN_B, 1'b0);
      dec(24'h00C000, XPS_T_LARGE_XRAM, 1'b0);
      dec(24'h00ECFF, XPS_T_TIMEKEEPER, 1'b0);
      wr(8'h24, 16'h0000);
      st(5'h00, 3'b000);
      foreach (ext_list[i]) dec(ext_list[i], XPS_T_EXTERNAL, 1'b0);
      @(posedge ref_clk);
      power_down_req <= 1'b1;
      repeat (6) @(posedge ref_clk);
      st(5'h00, 3'b100);
      wr(8'h24, 16'h0010);
      st(5'h10, 3'b000);
      wr(8'h28, 16'h0002);
      st(5'h10, 3'b100);
      @(posedge ref_clk);
      power_down_req <= 1'b0;
      rd(8'h30, 16'h0000);
      @(posedge ref_clk);
      emulation_mode <= 1'b1;
      repeat (6) @(posedge ref_clk);
      st(5'h1F, 3'b011);
      rd(8'h2C, 16'h003F);
      dec(24'h00EF10, XPS_T_CAN_A, 1'b0);
      @(posedge ref_clk);
      emulation_mode <= 1'b0;
      repeat (6) @(posedge ref_clk);
      wr(8'h28, 16'h0001);
      wr(8'h24, 16'h001F);
      rd(8'h24, 16'h0010);
      st(5'h10, 3'b000);
      print_verdict;
   end
endmodule
bind xps_select_decode xps_select_decode_asserts chk (.ref_clk, .arst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .emulation_mode, .power_down_req, .acc_valid, .acc_addr,
   .acc_route_valid, .acc_target, .acc_blocked, .acc_ext_addr, .can_a_pins_active,
   .can_b_pins_active, .periph_enable, .osc_stop);
